/* hdl/qdp_pkg.sv */
// constants shared by the quad converter serial input port
// assumes a single 10 MHz core clock and a sampled serial link
`default_nettype none
package qdp_pkg;
   // core clock and link timing
   localparam int CLK_PERIOD_NS   = 100;
   localparam int LINK_MAX_MHZ    = 50;
   // frame shape
   localparam int FRAME_BITS      = 32;
   localparam int CNT_W           = 5;
   localparam logic [CNT_W-1:0] CNT_LAST = 5'h1F;
   // channels and codes
   localparam int NCH             = 4;
   localparam int CODE_W          = 16;
   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam logic [15:0] CODE_MID  = 16'h8000;
   localparam logic [15:0] CODE_FULL = 16'hFFFF;
   // clear code register encodings
   localparam logic [1:0] CLR_SEL_ZERO = 2'h0;
   localparam logic [1:0] CLR_SEL_MID  = 2'h1;
   localparam logic [1:0] CLR_SEL_FULL = 2'h2;
   localparam logic [1:0] CLR_SEL_RST  = CLR_SEL_ZERO;
   // command word fields
   localparam int CMD_LSB         = 24;
   localparam int ADDR_LSB        = 20;
   localparam int DATA_LSB        = 4;
   localparam logic [3:0] CMD_WR_INPUT = 4'h0;
   localparam logic [3:0] CMD_CLR_CODE = 4'h2;
   localparam logic [3:0] CMD_REF_SEL  = 4'h3;
   localparam logic [3:0] ADDR_ALL     = 4'hF;
   // sampled pins, bit positions and idle levels
   localparam int PINS_W          = 6;
   localparam int PIN_SCLK        = 0;
   localparam int PIN_SYNC        = 1;
   localparam int PIN_SDIN        = 2;
   localparam int PIN_LOAD        = 3;
   localparam int PIN_CLR         = 4;
   localparam int PIN_POR         = 5;
   localparam logic [5:0] PIN_IDLE = 6'h1B;
   // strap settle time after reset release
   localparam logic [1:0] POR_WAIT = 2'h3;
   // buffer between link and channel registers
   localparam int FIFO_W          = 32;
   localparam int FIFO_DEPTH      = 8;
   localparam int FIFO_AW         = 3;
   // frame receiver states
   typedef enum logic [2:0] {
      QDP_IDLE  = 3'b001,
      QDP_SHIFT = 3'b010,
      QDP_WAIT  = 3'b100
   } qdp_state_t;
endpackage
`default_nettype wire

/* hdl/qdp_fifo.sv */
// small first-in first-out buffer with a registered head word
// assumes depth is a power of two and one clock for both sides
`default_nettype none
module qdp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wptr_r;
   logic [AW-1:0]    wptr_nxt;
   logic [AW-1:0]    rptr_r;
   logic [AW-1:0]    rptr_nxt;
   logic [AW:0]      cnt_r;
   logic [AW:0]      cnt_nxt;
   logic             hd_valid_r;
   logic             hd_valid_nxt;
   logic [WIDTH-1:0] out_data_r;
   logic             push;
   logic             load;

   // pointer, fill count and head register next values
   always_comb
   begin
      in_ready     = (cnt_r != (AW+1)'(DEPTH));
      push         = in_valid & in_ready;
      load         = (cnt_r != '0) & (~hd_valid_r | out_ready);
      wptr_nxt     = push ? wptr_r + 1'b1 : wptr_r;
      rptr_nxt     = load ? rptr_r + 1'b1 : rptr_r;
      cnt_nxt      = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      hd_valid_nxt = load | (hd_valid_r & ~out_ready);
   end

   // state registers
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         wptr_r     <= '0;
         rptr_r     <= '0;
         cnt_r      <= '0;
         hd_valid_r <= 1'b0;
      end
      else
      begin
         wptr_r     <= wptr_nxt;
         rptr_r     <= rptr_nxt;
         cnt_r      <= cnt_nxt;
         hd_valid_r <= hd_valid_nxt;
      end
   end

   // storage and registered read port
   always_ff @(posedge clk)
   begin
      if (push)
         mem_r[wptr_r] <= in_data;
      if (load)
         out_data_r <= mem_r[rptr_r];
   end

   assign out_valid = hd_valid_r;
   assign out_data  = out_data_r;
endmodule
`default_nettype wire

/* hdl/qdp_serial_port.sv */
// serial write port and update/clear control of a quad 16-bit converter
// assumes all pins arrive asynchronously and are sampled by core_clk
`default_nettype none
// What this block does
// - frame sync low arms the shifter; 32 falling clock edges then sampled
// - frame sync rising before the 32nd fall aborts; nothing is changed
// - shift register is 32 bits; data captured on serial clock falling edge
// - load strobe low copies new input data to outputs, all together
// - load strobe held permanently low keeps updating correctly
// - power-on code is zero with strap low, midscale with strap high
// - reference pin is an input until the internal reference is selected
// - serial output shifts on rising edge, valid for the next falling edge
// - clear falling edge loads every channel with the clear code value
// - load strobe is ignored while clear is held low
// - clear code register resets to the zero code
// - codes are 16-bit unsigned; zero 0000, midscale 8000, full FFFF
module qdp_serial_port (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // serial link pins
   input  wire logic        sclk,
   input  wire logic        sync_n,
   input  wire logic        sdin,
   output logic             serial_out,
   // update and clear pins
   input  wire logic        load_strobe_n,
   input  wire logic        async_clear_n,
   input  wire logic        por_level,
   // drain control and status
   input  wire logic        apply_hold,
   output logic             link_ready,
   output logic             frame_dropped,
   output logic             ref_is_output,
   // converter codes
   output logic [15:0]      code_a,
   output logic [15:0]      code_b,
   output logic [15:0]      code_c,
   output logic [15:0]      code_d
);
   // code for a clear or strap selection
   function automatic logic [15:0] sel_code(input logic [1:0] sel);
      logic [15:0] c;
      c = qdp_pkg::CODE_ZERO;
      if (sel == qdp_pkg::CLR_SEL_MID)
         c = qdp_pkg::CODE_MID;
      else if (sel == qdp_pkg::CLR_SEL_FULL)
         c = qdp_pkg::CODE_FULL;
      return c;
   endfunction

   // pin synchronisers
   logic [5:0]  pins_in;
   logic [5:0]  s1_r;
   logic [5:0]  s2_r;
   logic [5:0]  s3_r;
   logic [5:0]  s1_nxt;
   logic [5:0]  s2_nxt;
   logic [5:0]  s3_nxt;
   // frame receiver
   qdp_pkg::qdp_state_t state_r;
   qdp_pkg::qdp_state_t state_nxt;
   logic [4:0]  cnt_r;
   logic [4:0]  cnt_nxt;
   logic [31:0] sr_r;
   logic [31:0] sr_nxt;
   logic        sout_r;
   logic        sout_nxt;
   logic        push;
   logic        drop_r;
   logic        drop_nxt;
   // sampled pin events
   logic        sclk_fall;
   logic        sclk_rise;
   logic        sync_fall;
   logic        sync_high;
   logic        clr_fall;
   logic        clr_low;
   logic        load_low;
   // buffer
   logic        fifo_ready;
   logic        fifo_valid;
   logic [31:0] fifo_data;
   logic        take;
   // channel and control registers
   logic [3:0][15:0] in_r;
   logic [3:0][15:0] in_nxt;
   logic [3:0][15:0] out_r;
   logic [3:0][15:0] out_nxt;
   logic [3:0]  new_r;
   logic [3:0]  new_nxt;
   logic [1:0]  clr_sel_r;
   logic [1:0]  clr_sel_nxt;
   logic        ref_r;
   logic        ref_nxt;
   logic [1:0]  por_cnt_r;
   logic [1:0]  por_cnt_nxt;
   logic        por_done_r;
   logic        por_done_nxt;
   // command fields
   logic [3:0]  cmd;
   logic [3:0]  addr;
   logic [15:0] wdata;

   // gather pins into one vector for sampling
   always_comb
   begin
      pins_in = '0;
      pins_in[qdp_pkg::PIN_SCLK] = sclk;
      pins_in[qdp_pkg::PIN_SYNC] = sync_n;
      pins_in[qdp_pkg::PIN_SDIN] = sdin;
      pins_in[qdp_pkg::PIN_LOAD] = load_strobe_n;
      pins_in[qdp_pkg::PIN_CLR]  = async_clear_n;
      pins_in[qdp_pkg::PIN_POR]  = por_level;
      s1_nxt = pins_in;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
   end

   // two-stage synchroniser plus one history stage for edges
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         s1_r <= qdp_pkg::PIN_IDLE;
         s2_r <= qdp_pkg::PIN_IDLE;
         s3_r <= qdp_pkg::PIN_IDLE;
      end
      else
      begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
      end
   end

   // edge and level decode on the synchronised pins
   assign sclk_fall = s3_r[qdp_pkg::PIN_SCLK] & ~s2_r[qdp_pkg::PIN_SCLK];
   assign sclk_rise = ~s3_r[qdp_pkg::PIN_SCLK] & s2_r[qdp_pkg::PIN_SCLK];
   assign sync_fall = s3_r[qdp_pkg::PIN_SYNC] & ~s2_r[qdp_pkg::PIN_SYNC];
   assign sync_high = s2_r[qdp_pkg::PIN_SYNC];
   assign clr_fall  = s3_r[qdp_pkg::PIN_CLR] & ~s2_r[qdp_pkg::PIN_CLR];
   assign clr_low   = ~s2_r[qdp_pkg::PIN_CLR];
   assign load_low  = ~s2_r[qdp_pkg::PIN_LOAD];

   // frame receiver next state
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      sr_nxt    = sr_r;
      sout_nxt  = sout_r;
      push      = 1'b0;
      drop_nxt  = 1'b0;
      // daisy output follows the shifter on every rising edge
      if (sclk_rise)
         sout_nxt = sr_r[qdp_pkg::FRAME_BITS-1];
      case (state_r)
         qdp_pkg::QDP_IDLE:
         begin
            if (sync_fall)
            begin
               state_nxt = qdp_pkg::QDP_SHIFT;
               cnt_nxt   = '0;
            end
         end
         qdp_pkg::QDP_SHIFT:
         begin
            if (sync_high)
               state_nxt = qdp_pkg::QDP_IDLE;
            else if (sclk_fall)
            begin
               sr_nxt  = {sr_r[30:0], s2_r[qdp_pkg::PIN_SDIN]};
               cnt_nxt = cnt_r + 1'b1;
               if (cnt_r == qdp_pkg::CNT_LAST)
               begin
                  push      = fifo_ready;
                  drop_nxt  = ~fifo_ready;
                  state_nxt = qdp_pkg::QDP_WAIT;
               end
            end
         end
         qdp_pkg::QDP_WAIT:
         begin
            if (sync_high)
               state_nxt = qdp_pkg::QDP_IDLE;
         end
         default:
            state_nxt = qdp_pkg::QDP_IDLE;
      endcase
   end

   // frame receiver registers
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         state_r <= qdp_pkg::QDP_IDLE;
         cnt_r   <= '0;
         sr_r    <= '0;
         sout_r  <= 1'b0;
         drop_r  <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         sr_r    <= sr_nxt;
         sout_r  <= sout_nxt;
         drop_r  <= drop_nxt;
      end
   end

   // completed frames wait here until the channel logic takes them
   qdp_fifo #(
      .WIDTH (qdp_pkg::FIFO_W),
      .DEPTH (qdp_pkg::FIFO_DEPTH),
      .AW    (qdp_pkg::FIFO_AW)
   ) qdp_fifo_inst (
      .clk       (core_clk),
      .resetn    (resetn),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .in_data   (sr_nxt),
      .out_valid (fifo_valid),
      .out_ready (take),
      .out_data  (fifo_data)
   );

   // command fields of the head word
   assign cmd   = fifo_data[qdp_pkg::CMD_LSB +: 4];
   assign addr  = fifo_data[qdp_pkg::ADDR_LSB +: 4];
   assign wdata = fifo_data[qdp_pkg::DATA_LSB +: qdp_pkg::CODE_W];
   assign take  = fifo_valid & por_done_r & ~apply_hold;

   // channel, clear code and reference next values
   always_comb
   begin
      in_nxt       = in_r;
      out_nxt      = out_r;
      new_nxt      = new_r;
      clr_sel_nxt  = clr_sel_r;
      ref_nxt      = ref_r;
      por_cnt_nxt  = por_cnt_r;
      por_done_nxt = por_done_r;
      // strap is read once the synchronisers have settled
      if (!por_done_r)
      begin
         if (por_cnt_r == qdp_pkg::POR_WAIT)
         begin
            por_done_nxt = 1'b1;
            for (int i = 0; i < qdp_pkg::NCH; i++)
            begin
               in_nxt[i]  = sel_code(s2_r[qdp_pkg::PIN_POR] ?
                               qdp_pkg::CLR_SEL_MID :
                               qdp_pkg::CLR_SEL_ZERO);
               out_nxt[i] = in_nxt[i];
            end
         end
         else
            por_cnt_nxt = por_cnt_r + 1'b1;
      end
      // update pending channels while load is low and clear is high
      if (load_low && !clr_low)
      begin
         for (int i = 0; i < qdp_pkg::NCH; i++)
         begin
            if (new_r[i])
            begin
               out_nxt[i] = in_r[i];
               new_nxt[i] = 1'b0;
            end
         end
      end
      // clear overrides every channel in the same cycle
      if (clr_fall)
      begin
         for (int i = 0; i < qdp_pkg::NCH; i++)
            out_nxt[i] = sel_code(clr_sel_r);
      end
      // apply one buffered command; a new write re-arms its channel
      if (take)
      begin
         if (cmd == qdp_pkg::CMD_WR_INPUT)
         begin
            for (int i = 0; i < qdp_pkg::NCH; i++)
            begin
               if (addr == qdp_pkg::ADDR_ALL || addr == 4'(i))
               begin
                  in_nxt[i]  = wdata;
                  new_nxt[i] = 1'b1;
               end
            end
         end
         else if (cmd == qdp_pkg::CMD_CLR_CODE)
            clr_sel_nxt = wdata[1:0];
         else if (cmd == qdp_pkg::CMD_REF_SEL)
            ref_nxt = wdata[0];
      end
   end

   // channel, clear code and reference registers
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         in_r       <= '0;
         out_r      <= '0;
         new_r      <= '0;
         clr_sel_r  <= qdp_pkg::CLR_SEL_RST;
         ref_r      <= 1'b0;
         por_cnt_r  <= '0;
         por_done_r <= 1'b0;
      end
      else
      begin
         in_r       <= in_nxt;
         out_r      <= out_nxt;
         new_r      <= new_nxt;
         clr_sel_r  <= clr_sel_nxt;
         ref_r      <= ref_nxt;
         por_cnt_r  <= por_cnt_nxt;
         por_done_r <= por_done_nxt;
      end
   end

   // outputs, all from registers except the buffer ready
   assign serial_out    = sout_r;
   assign link_ready    = fifo_ready;
   assign frame_dropped = drop_r;
   assign ref_is_output = ref_r;
   assign code_a        = out_r[0];
   assign code_b        = out_r[1];
   assign code_c        = out_r[2];
   assign code_d        = out_r[3];
endmodule
`default_nettype wire

/* sim/qdp_host.sv */
// host side of the serial link: frames, clock and data line
// assumes the bench calls send between frames only
`default_nettype none
module qdp_host (
   // core clock and daisy input
   input  wire logic  core_clk,
   input  wire logic  serial_out,
   // link pins
   output logic       sclk,
   output logic       sync_n,
   output logic       sdin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] rx;
   // idle: clock stands high, sync high
   initial
   begin
      sclk = 1'b1;
      sync_n = 1'b1;
      sdin = 1'b0;
      rx = 32'h0;
   end
   // one frame, msb first; fewer than 32 bits aborts it
   task automatic send(input logic [31:0] w, input int nbits);
      @(negedge core_clk) sync_n = 1'b0;
      repeat (4) @(negedge core_clk);
      for (int i = 31; i > 31 - nbits; i--)
      begin
         sdin = w[i];
         repeat (4) @(negedge core_clk);
         sclk = 1'b0; // 800 ns period, far below 50 MHz
         rx = {rx[30:0], serial_out};
         repeat (4) @(negedge core_clk);
         sclk = 1'b1;
      end
      repeat (4) @(negedge core_clk);
      sync_n = 1'b1;
      sdin = ~sdin; // released line shows no stale value
      repeat (4) @(negedge core_clk);
   endtask
endmodule
`default_nettype wire

/* sim/qdp_serial_port_chk.sv */
// port checker of the serial port, bound to the top module
// assumes one core clock domain and synchronous active-low reset
`default_nettype none
module qdp_serial_port_chk (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // pins
   input  wire logic        sclk,
   input  wire logic        sync_n,
   input  wire logic        sdin,
   input  wire logic        serial_out,
   input  wire logic        load_strobe_n,
   input  wire logic        async_clear_n,
   input  wire logic        por_level,
   input  wire logic        apply_hold,
   input  wire logic        link_ready,
   input  wire logic        frame_dropped,
   input  wire logic        ref_is_output,
   input  wire logic [15:0] code_a,
   input  wire logic [15:0] code_b,
   input  wire logic [15:0] code_c,
   input  wire logic [15:0] code_d
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic [2:0]       age_r;
   wire logic [63:0] codes = {code_a, code_b, code_c, code_d};
   // cycles since reset, to skip the strap load
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
         age_r <= 3'h0;
      else if (age_r != 3'h7)
         age_r <= age_r + 3'h1;
   end
   sequence s_clr_low;
      $fell(async_clear_n) ##1 !async_clear_n [*4];
   endsequence
   property p_clr_fill;
      s_clr_low |-> code_a == code_b && code_b == code_c
         && code_c == code_d && (code_a == 16'h0000
         || code_a == 16'h8000 || code_a == 16'hFFFF);
   endproperty
   a_clr_fill: assert property (p_clr_fill)
      else $error("clear left channels unequal");
   property p_clr_hold;
      !async_clear_n [*6] |-> $stable(codes);
   endproperty
   a_clr_hold: assert property (p_clr_hold)
      else $error("codes moved while clear low");
   property p_out_cause;
      $changed(codes) && age_r == 3'h7 |-> !$past(load_strobe_n, 2)
         || !$past(load_strobe_n, 3) || !$past(async_clear_n, 2)
         || !$past(async_clear_n, 3);
   endproperty
   a_out_cause: assert property (p_out_cause)
      else $error("codes moved without load or clear");
   property p_sout_edge;
      $changed(serial_out) |-> $past(sclk, 1) && $past(sclk, 2);
   endproperty
   a_sout_edge: assert property (p_sout_edge)
      else $error("serial output moved off a rising clock");
   property p_por;
      $rose(resetn) |-> ##[4:6] codes == {4{por_level ?
         qdp_pkg::CODE_MID : qdp_pkg::CODE_ZERO}};
   endproperty
   a_por: assert property (p_por)
      else $error("strap code not loaded");
   property p_ref_rst;
      $rose(resetn) |-> !ref_is_output [*4];
   endproperty
   a_ref_rst: assert property (p_ref_rst)
      else $error("reference pin not an input after reset");
   property p_drop_pulse;
      frame_dropped |=> !frame_dropped;
   endproperty
   a_drop_pulse: assert property (p_drop_pulse)
      else $error("drop flag longer than one cycle");
   property p_drop_full;
      frame_dropped |-> !$past(link_ready);
   endproperty
   a_drop_full: assert property (p_drop_full)
      else $error("frame dropped with room in buffer");
endmodule
`default_nettype wire

/* sim/qdp_serial_port_bench.sv */
// self-checking bench of the serial port with a host model
// assumes qdp_pkg, qdp_fifo, qdp_host and the checker are compiled first
`default_nettype none
module qdp_serial_port_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk, resetn, load_strobe_n, async_clear_n;
   logic        por_level, apply_hold, drop_seen;
   wire logic   sclk, sync_n, sdin, serial_out;
   wire logic   link_ready, frame_dropped, ref_is_output;
   wire logic [15:0] code_a, code_b, code_c, code_d;
   wire logic [63:0] codes = {code_a, code_b, code_c, code_d};
   int          fail_count, checks;
   qdp_serial_port qdp_serial_port_inst (
      .core_clk(core_clk), .resetn(resetn), .sclk(sclk),
      .sync_n(sync_n), .sdin(sdin), .serial_out(serial_out),
      .load_strobe_n(load_strobe_n), .async_clear_n(async_clear_n),
      .por_level(por_level), .apply_hold(apply_hold),
      .link_ready(link_ready), .frame_dropped(frame_dropped),
      .ref_is_output(ref_is_output), .code_a(code_a),
      .code_b(code_b), .code_c(code_c), .code_d(code_d));
   qdp_host qdp_host_inst (
      .core_clk(core_clk), .serial_out(serial_out), .sclk(sclk),
      .sync_n(sync_n), .sdin(sdin));
   // clock and sticky drop flag
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk)
      if (frame_dropped === 1'b1)
         drop_seen <= 1'b1;
   task check(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] word(input logic [3:0] cmd,
      input logic [3:0] addr, input logic [15:0] data);
      return {4'h0, cmd, addr, data, 4'h0};
   endfunction
   function automatic logic [15:0] clr_val(input logic [1:0] s);
      return (s == 2'h1) ? 16'h8000 : (s == 2'h2) ? 16'hFFFF : 16'h0000;
   endfunction
   task wait_n(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task do_reset(input logic por);
      @(negedge core_clk) resetn = 1'b0;
      por_level = por;
      wait_n(2);
      resetn = 1'b1;
      wait_n(8);
   endtask
   task pulse_load;
      load_strobe_n = 1'b0;
      wait_n(3);
      load_strobe_n = 1'b1;
      wait_n(8);
   endtask
   task set_clr(input logic lvl);
      async_clear_n = lvl;
      wait_n(8);
   endtask
   task send(input logic [31:0] w);
      qdp_host_inst.send(w, 32);
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // watchdog
   initial
   begin
      #3000000;
      fail_count++;
      results();
   end
   // main sequence
   initial
   begin
      logic [15:0] v [4];
      core_clk = 1'b0;
      resetn = 1'b0;
      load_strobe_n = 1'b1;
      async_clear_n = 1'b1;
      por_level = 1'b0;
      apply_hold = 1'b0;
      drop_seen = 1'b0;
      fail_count = 0;
      checks = 0;
      void'($urandom(32'hF98E));
      for (int p = 0; p < 2; p++)
      begin
         do_reset(p[0]);
         check(codes, {4{clr_val({1'b0, p[0]})}});
         check(ref_is_output, 1'b0);
      end
      set_clr(1'b0);
      check(codes, 64'h0);
      set_clr(1'b1);
      foreach (v[i])
      begin
         v[i] = (i == 3) ? 16'hFFFF : 16'($urandom());
         send(word(qdp_pkg::CMD_WR_INPUT, 4'(i), v[i]));
      end
      wait_n(12);
      check(codes, 64'h0);
      check(qdp_host_inst.rx, word(4'h0, 4'h2, v[2]));
      pulse_load();
      check(codes, {v[0], v[1], v[2], v[3]});
      qdp_host_inst.send(word(4'h0, 4'h0, ~v[0]), 31);
      pulse_load();
      check(codes, {v[0], v[1], v[2], v[3]});
      // unknown address and unknown command must touch no channel
      send(word(qdp_pkg::CMD_WR_INPUT, 4'h5, ~v[0]));
      send(word(4'h1, 4'h0, ~v[0]));
      pulse_load();
      check(codes, {v[0], v[1], v[2], v[3]});
      load_strobe_n = 1'b0;
      send(word(qdp_pkg::CMD_WR_INPUT, qdp_pkg::ADDR_ALL, v[1]));
      wait_n(12);
      check(codes, {4{v[1]}});
      load_strobe_n = 1'b1;
      for (int c = 0; c < 4; c++)
      begin
         send(word(qdp_pkg::CMD_CLR_CODE, 4'h0, 16'(c)));
         send(word(qdp_pkg::CMD_WR_INPUT, qdp_pkg::ADDR_ALL, 16'h1234));
         wait_n(12);
         set_clr(1'b0);
         check(codes, {4{clr_val(2'(c))}});
         pulse_load();
         check(codes, {4{clr_val(2'(c))}});
         set_clr(1'b1);
      end
      for (int r = 1; r >= 0; r--)
      begin
         send(word(qdp_pkg::CMD_REF_SEL, 4'h0, 16'(r)));
         wait_n(12);
         check(ref_is_output, r[0]);
      end
      apply_hold = 1'b1;
      for (int f = 0; f < 10; f++)
         send(word(qdp_pkg::CMD_WR_INPUT, 4'h0, 16'(f) + 16'h0100));
      check(link_ready, 1'b0);
      check(drop_seen, 1'b1);
      apply_hold = 1'b0;
      wait_n(40);
      pulse_load();
      check(code_a, 16'h0108);
      results();
   end
endmodule
bind qdp_serial_port qdp_serial_port_chk qdp_serial_port_chk_inst (
   .core_clk(core_clk), .resetn(resetn), .sclk(sclk), .sync_n(sync_n),
   .sdin(sdin), .serial_out(serial_out), .load_strobe_n(load_strobe_n),
   .async_clear_n(async_clear_n), .por_level(por_level),
   .apply_hold(apply_hold), .link_ready(link_ready),
   .frame_dropped(frame_dropped), .ref_is_output(ref_is_output),
   .code_a(code_a), .code_b(code_b), .code_c(code_c), .code_d(code_d));
`default_nettype wire
